// file: core/adccs_top.sv
// Conversion sequencer for the on-chip successive-approximation converter.
//
// Notes on behaviour
// RULE1: resolution_select at 0 selects 12-bit conversion.
// RULE2: time code 1,0,1 selects division ratio 1/32.
// RULE3: control bits 7..4 choose the channel; 0101 is channel five.
// RULE4: writing 1 to convert_go starts a conversion with current settings.
// RULE5: first 12-bit conversion after reset or 8-to-12 switch takes double time.
// RULE6: other conversions take the normal formula time.
// RULE7: completion sets conversion_done_flag and clears convert_go together.
// RULE8: with irq enable set, completion raises the interrupt request.
// RULE9: software clears the done flag itself; hardware never does.
// RULE10: software may poll the done flag until it reads 1.
// RULE11: writing 0 to convert_go mid-conversion stops it; no valid result.
// RULE12: reset during a conversion clears convert_go and halts the converter.
// RULE13: software keeps convert_go at 0 before entering hold state.
// RULE14: software reads results after completion, then restarts.
// RULE15: oscillator run bit also runs the reference voltage generator.
// RULE16: reference voltage is a selectable converter input channel.
// RULE17: software should average several results, dropping extremes.
// RULE18: 8-bit result goes to high byte only; 12-bit low nibble to low[7:4].
// RULE19: time code n selects division ratio one over two to the n.
// RULE20: time is (52 or 32 over ratio, plus 2) thirds of a cycle.
// RULE21: result registers change only when a conversion completes; here APB writes to them also load them.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps

module adccs_top (
	// Clock, reset, enable
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                ce,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Analog converter macro
	input  wire logic [11:0]         conv_sample,
	output logic      [3:0]          channel_sel,
	output logic                     ref_channel_sel,
	output logic                     conv_running,
	output logic                     conv_res_8bit,
	output logic      [2:0]          conv_div_code,
	// Interrupt request
	output logic                     conv_irq,
	// Oscillator and reference generator
	output logic                     rc_osc_run,
	output logic                     rc_osc_clock_select,
	output logic                     ref_gen_enable
);
	import adccs_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// Register state

	logic [3:0]   chan_r;
	logic         go_r;
	logic         done_r;
	logic         irq_en_r;
	logic         res8_r;
	logic [1:0]   tm_lo_r;
	logic         tm_hi_r;
	logic [3:0]   res_low_r;
	logic [7:0]   res_high_r;
	logic         osc_run_r;
	logic         osc_sel_r;
	logic         first12_r;
	adccs_state_t state_r;
	logic [15:0]  cnt_r;
	logic         run_res8_r;

	//////////////////////////////////////////////////////////////////////
	// APB decode

	logic        sel_rc;
	logic        sel_ctl;
	logic        sel_mode;
	logic        sel_low;
	logic        sel_high;
	logic        mapped;
	logic        wr_en;
	logic [7:0]  wdat;
	logic [7:0]  rd_byte;

	assign sel_rc   = paddr[31:2] == IDX_RC_OSC;
	assign sel_ctl  = paddr[31:2] == IDX_CONTROL;
	assign sel_mode = paddr[31:2] == IDX_MODE;
	assign sel_low  = paddr[31:2] == IDX_RES_LOW;
	assign sel_high = paddr[31:2] == IDX_RES_HIGH;
	assign mapped   = (paddr[1:0] == 2'h0)
		&& (sel_rc || sel_ctl || sel_mode || sel_low || sel_high);
	assign wr_en    = ce && psel && penable && pready && pwrite && mapped;
	assign wdat     = pwdata[7:0];

	always_comb begin
		rd_byte = 8'h00;
		if (sel_rc) begin
			rd_byte = {osc_sel_r, osc_run_r, RC_OSC_FILL};
		end else if (sel_ctl) begin
			rd_byte = {chan_r, 1'b0, go_r, done_r, irq_en_r};
		end else if (sel_mode) begin
			rd_byte = {1'b0, res8_r, 4'h0, tm_lo_r};
		end else if (sel_low) begin
			rd_byte = {res_low_r, 3'h0, tm_hi_r};
		end else if (sel_high) begin
			rd_byte = res_high_r;
		end
	end

	// Answer in the first access cycle; data and error held until done
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= psel && !penable;
			if (psel && !penable) begin
				prdata  <= (mapped && !pwrite) ? {24'h000000, rd_byte}
					: 32'h00000000;
				pslverr <= !mapped;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Conversion timing

	logic [2:0]  div_code;
	logic [15:0] units;
	logic [15:0] conv_clks;
	logic        long_conv;
	logic        start;
	logic        abort;
	logic        finish;

	assign div_code = {tm_hi_r, tm_lo_r};                         // RULE2
	// Ratio 1/2^n turns base/ratio into a left shift by n
	assign units = ((res8_r ? BASE_UNITS_8 : BASE_UNITS_12)       // RULE20
		<< div_code) + EXTRA_UNITS;                               // RULE19
	assign long_conv = !res8_r && first12_r;                      // RULE5
	assign conv_clks = 16'((long_conv ? (units << 1) : units)     // RULE6
		* THIRD_TCYC_CLKS);

	assign start  = wr_en && sel_ctl && wdat[GO_BIT]              // RULE4
		&& (state_r == ADCCS_IDLE);
	assign abort  = wr_en && sel_ctl && !wdat[GO_BIT]             // RULE11
		&& (state_r == ADCCS_CONV);
	assign finish = (state_r == ADCCS_CONV) && (cnt_r == 16'h0001)
		&& !abort;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= ADCCS_IDLE;                             // RULE12
			cnt_r      <= 16'h0000;
			run_res8_r <= 1'b0;
		end else if (ce) begin
			case (state_r)
				ADCCS_IDLE: begin
					if (start) begin
						state_r    <= ADCCS_CONV;
						cnt_r      <= conv_clks;
						run_res8_r <= res8_r;                     // RULE1
					end
				end
				ADCCS_CONV: begin
					if (abort || finish) begin
						state_r <= ADCCS_IDLE;
						cnt_r   <= 16'h0000;
					end else begin
						cnt_r <= cnt_r - 16'h0001;
					end
				end
				default: begin
					state_r <= ADCCS_IDLE;
					cnt_r   <= 16'h0000;
				end
			endcase
		end
	end

	// Pending long conversion: set by reset and by an 8-to-12 switch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			first12_r <= 1'b1;                                    // RULE5
		end else if (ce) begin
			if (wr_en && sel_mode && res8_r && !wdat[RES_SEL_BIT]) begin
				first12_r <= 1'b1;                                // RULE5
			end else if (finish && !run_res8_r) begin
				first12_r <= 1'b0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Control register

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chan_r   <= RST_CONTROL[CH_SEL_HI:CH_SEL_LO];
			go_r     <= RST_CONTROL[GO_BIT];                      // RULE12
			done_r   <= RST_CONTROL[DONE_BIT];
			irq_en_r <= RST_CONTROL[IRQ_EN_BIT];
		end else if (ce) begin
			if (wr_en && sel_ctl) begin
				chan_r   <= wdat[CH_SEL_HI:CH_SEL_LO];            // RULE3
				irq_en_r <= wdat[IRQ_EN_BIT];
			end
			// A new start wins the go bit; completion clears it otherwise
			if (start) begin
				go_r <= 1'b1;                                     // RULE4
			end else if (finish || abort) begin
				go_r <= 1'b0;                                     // RULE7
			end
			// Completion wins over a software clear in the same cycle
			if (finish) begin
				done_r <= 1'b1;                                   // RULE7
			end else if (wr_en && sel_ctl) begin
				done_r <= wdat[DONE_BIT];                         // RULE9
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Mode, timing and result registers

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			res8_r  <= RST_MODE[RES_SEL_BIT];
			tm_lo_r <= RST_MODE[TM_MID_BIT:TM_LO_BIT];
		end else if (ce && wr_en && sel_mode) begin
			res8_r  <= wdat[RES_SEL_BIT];                         // RULE1
			tm_lo_r <= wdat[TM_MID_BIT:TM_LO_BIT];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tm_hi_r   <= RST_RES_LOW[TM_HI_BIT];
			res_low_r <= RST_RES_LOW[RES_LOW_HI:RES_LOW_LO];
		end else if (ce) begin
			if (wr_en && sel_low) begin
				tm_hi_r <= wdat[TM_HI_BIT];
			end
			if (finish && !run_res8_r) begin
				res_low_r <= conv_sample[3:0];                    // RULE18
			end else if (wr_en && sel_low) begin
				res_low_r <= wdat[RES_LOW_HI:RES_LOW_LO];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			res_high_r <= RST_RES_HIGH;
		end else if (ce) begin
			if (finish) begin
				res_high_r <= conv_sample[11:4];                  // RULE21
			end else if (wr_en && sel_high) begin
				res_high_r <= wdat;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Oscillator control

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			osc_run_r <= RST_OSC_BIT;
			osc_sel_r <= RST_OSC_BIT;
		end else if (ce && wr_en && sel_rc) begin
			osc_run_r <= wdat[RC_RUN_BIT];
			osc_sel_r <= wdat[RC_CLK_SEL_BIT];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Registered outputs

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			channel_sel         <= 4'h0;
			ref_channel_sel     <= 1'b0;
			conv_running        <= 1'b0;
			conv_res_8bit       <= 1'b0;
			conv_div_code       <= 3'h0;
			conv_irq            <= 1'b0;
			rc_osc_run          <= 1'b0;
			rc_osc_clock_select <= 1'b0;
			ref_gen_enable      <= 1'b0;
		end else if (ce) begin
			channel_sel         <= chan_r;                        // RULE3
			ref_channel_sel     <= chan_r == CH_REF_VOLTAGE;      // RULE16
			conv_running        <= go_r;
			conv_res_8bit       <= res8_r;
			conv_div_code       <= div_code;
			conv_irq            <= done_r && irq_en_r;            // RULE8
			rc_osc_run          <= osc_run_r;
			rc_osc_clock_select <= osc_sel_r;
			ref_gen_enable      <= osc_run_r;                     // RULE15
		end
	end

endmodule : adccs_top

// file: core/adccs_pkg.sv
// Constants shared by the converter sequencer and its verification.
package adccs_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [29:0] IDX_RC_OSC   = 30'h0000fe0d;
	localparam logic [29:0] IDX_CONTROL  = 30'h0000fe58;
	localparam logic [29:0] IDX_MODE     = 30'h0000fe59;
	localparam logic [29:0] IDX_RES_LOW  = 30'h0000fe5a;
	localparam logic [29:0] IDX_RES_HIGH = 30'h0000fe5b;

	// Reset values
	localparam logic [7:0] RST_CONTROL  = 8'h00;
	localparam logic [7:0] RST_MODE     = 8'h00;
	localparam logic [7:0] RST_RES_LOW  = 8'h00;
	localparam logic [7:0] RST_RES_HIGH = 8'h00;
	localparam logic       RST_OSC_BIT  = 1'b0;
	// Unimplemented oscillator control bits read as ones
	localparam logic [5:0] RC_OSC_FILL  = 6'h3f;

	// rc_osc_control fields
	localparam int RC_CLK_SEL_BIT = 7;
	localparam int RC_RUN_BIT     = 6;

	// converter_control fields
	localparam int CH_SEL_HI    = 7;
	localparam int CH_SEL_LO    = 4;
	localparam int GO_BIT       = 2;
	localparam int DONE_BIT     = 1;
	localparam int IRQ_EN_BIT   = 0;

	// converter_mode fields
	localparam int RES_SEL_BIT  = 6;
	localparam int TM_MID_BIT   = 1;
	localparam int TM_LO_BIT    = 0;

	// result_low_and_timing fields
	localparam int RES_LOW_HI   = 7;
	localparam int RES_LOW_LO   = 4;
	localparam int TM_HI_BIT    = 0;

	// Channel codes
	localparam logic [3:0] CH_ANALOG_FIVE = 4'h5;
	localparam logic [3:0] CH_REF_VOLTAGE = 4'he;

	// Conversion timing: units of one third of a cycle time
	localparam int CLK_PERIOD_NS   = 4;
	localparam int TCYC_NS         = 12;
	localparam int THIRD_TCYC_CLKS = (TCYC_NS + 3 * CLK_PERIOD_NS - 1)
		/ (3 * CLK_PERIOD_NS);
	localparam logic [15:0] BASE_UNITS_12 = 16'h0034;
	localparam logic [15:0] BASE_UNITS_8  = 16'h0020;
	localparam logic [15:0] EXTRA_UNITS   = 16'h0002;

	// Sequencer states
	typedef enum logic [1:0] {
		ADCCS_IDLE = 2'b01,
		ADCCS_CONV = 2'b10
	} adccs_state_t;

endpackage : adccs_pkg

// file: tb/adccs_props.sv
// Port checker for the conversion sequencer.
`timescale 1ns/1ps

module adccs_props
	import adccs_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        ce,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Converter side
	input wire logic [3:0]  channel_sel,
	input wire logic        ref_channel_sel,
	input wire logic        conv_running,
	input wire logic        conv_irq,
	input wire logic        rc_osc_run,
	input wire logic        ref_gen_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_setup;
		ce && psel && !penable;
	endsequence
	sequence s_ctl_wr;
		psel && penable && pready && pwrite
			&& paddr == {IDX_CONTROL, 2'b00};
	endsequence

	AST_READY_SETUP: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_SLVERR: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("unaligned access accepted");
	AST_START: assert property (
		s_ctl_wr ##0 (pwdata[GO_BIT] && !conv_running) |=> ##1 conv_running)
		else $error("conversion did not start");
	AST_ABORT: assert property (
		s_ctl_wr ##0 (!pwdata[GO_BIT] && conv_running) |=> ##1 !conv_running)
		else $error("conversion did not stop");
	AST_IRQ_END: assert property ($rose(conv_irq) |-> $fell(conv_running)
		|| $past(psel && penable && pready && pwrite
			&& paddr == {IDX_CONTROL, 2'b00}, 2))
		else $error("interrupt not tied to completion or enable");
	AST_OSC_REF: assert property (rc_osc_run == ref_gen_enable)
		else $error("reference generator not with oscillator");
	AST_REF_CH: assert property (
		ref_channel_sel == (channel_sel == CH_REF_VOLTAGE))
		else $error("reference channel select wrong");
endmodule : adccs_props

bind adccs_top adccs_props adccs_props_inst (.*);

// file: tb/adccs_analog.sv
// Analog front end model: channel levels and reference source.
`timescale 1ns/1ps

module adccs_analog (
	// Clock
	input  wire logic        clk,
	// Selection from the sequencer
	input  wire logic [3:0]  channel_sel,
	input  wire logic        ref_channel_sel,
	input  wire logic        ref_gen_enable,
	// Sample to the sequencer
	output logic      [11:0] conv_sample
);
	logic [11:0] noise_r = 12'h000;

	always_ff @(posedge clk) begin
		noise_r <= noise_r + 12'h3c7;
	end
	always_comb begin
		if (!ref_channel_sel) begin
			conv_sample = {3{channel_sel}};
		end else if (ref_gen_enable) begin
			conv_sample = 12'h6a5;
		end else begin
			conv_sample = noise_r;
		end
	end
endmodule : adccs_analog

// file: tb/adccs_top_test.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ps

module adccs_top_test;
	import adccs_pkg::*;
	logic        clk, resetn, ce, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata;
	logic        pready, pslverr, conv_running, conv_irq, conv_res_8bit;
	logic [11:0] conv_sample;
	logic [3:0]  channel_sel, ch;
	logic [2:0]  conv_div_code;
	logic        ref_channel_sel, rc_osc_run, rc_osc_clock_select;
	logic        ref_gen_enable;
	logic [32:0] rq[$];
	int          tq[$];
	int          n_fail, comparisons, run_len;

	adccs_top adccs_top_inst (.*);
	adccs_analog adccs_analog_inst (.*);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic apb(logic w, logic [31:0] a, logic [7:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk);
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(logic [29:0] i, logic [7:0] d);
		apb(1'b1, {i, 2'b00}, d);
	endtask : wr
	task automatic rd(logic [29:0] i, logic [7:0] e);
		rq.push_back({1'b0, 24'h000000, e});
		apb(1'b0, {i, 2'b00}, 8'h00);
	endtask : rd
	// Start a run and wait until the running flag drops
	task automatic conv(logic [7:0] c, int n);
		int k;
		k = 0;
		tq.push_back(n);
		wr(IDX_CONTROL, c);
		repeat (2) @(posedge clk);
		while (conv_running !== 1'b0 && k < 4000) begin
			@(posedge clk);
			k++;
		end
	endtask : conv
	////////////////////////////////////////////////////////////////////////
	// Monitor: read data and run lengths against the noted results
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0)
			chk("read", rq.pop_front(), {pslverr, prdata});
		if (conv_running === 1'b1) begin
			run_len++;
		end else if (run_len > 0) begin
			if (tq.size() > 0)
				chk("run length", 33'(tq.pop_front()), 33'(run_len));
			run_len = 0;
		end
	end
	initial begin
		#80000;
		n_fail++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		ce = 1'b1;
		{n_fail, comparisons, run_len} = '0;
		void'($urandom(88));
		ch = 4'($urandom % 7);
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		rd(IDX_CONTROL, RST_CONTROL);
		rd(IDX_MODE, RST_MODE);
		rd(IDX_RES_LOW, RST_RES_LOW);
		rd(IDX_RES_HIGH, RST_RES_HIGH);
		rd(IDX_RC_OSC, {2'b00, RC_OSC_FILL});
		rq.push_back({1'b1, 32'h0});
		apb(1'b0, {IDX_RES_HIGH, 2'b10}, 8'h00);
		conv(8'h54, 2 * (52 + 2));
		chk("irq", 33'h0, 33'(conv_irq));
		rd(IDX_CONTROL, 8'h52);
		rd(IDX_RES_HIGH, 8'h55);
		rd(IDX_RES_LOW, 8'h50);
		wr(IDX_CONTROL, 8'h50);
		wr(IDX_RES_LOW, 8'h01);
		wr(IDX_MODE, 8'h01);
		repeat (2) @(posedge clk);
		chk("div code", 33'h5, 33'(conv_div_code));
		conv({ch, 4'h5}, (52 << 5) + 2);
		chk("irq", 33'h1, 33'(conv_irq));
		rd(IDX_CONTROL, {ch, 4'h3});
		rd(IDX_RES_HIGH, {ch, ch});
		rd(IDX_RES_LOW, {ch, 4'h1});
		wr(IDX_CONTROL, {ch, 4'h0});
		repeat (2) @(posedge clk);
		chk("irq", 33'h0, 33'(conv_irq));
		wr(IDX_MODE, 8'h40);
		wr(IDX_RES_LOW, 8'h30);
		chk("res 8bit", 33'h1, 33'(conv_res_8bit));
		conv(8'h64, 32 + 2);
		rd(IDX_RES_HIGH, 8'h66);
		rd(IDX_RES_LOW, 8'h30);
		wr(IDX_CONTROL, 8'h60);
		wr(IDX_RC_OSC, 8'h40);
		rd(IDX_RC_OSC, 8'h7f);
		chk("osc run", 33'h1, 33'(rc_osc_run));
		wr(IDX_RC_OSC, 8'hc0);
		repeat (2) @(posedge clk);
		chk("clock select", 33'h1, 33'(rc_osc_clock_select));
		// Clock select back to 0 before the reference is converted
		wr(IDX_RC_OSC, 8'h40);
		wr(IDX_MODE, 8'h00);
		conv(8'he4, 2 * (52 + 2));
		rd(IDX_RES_HIGH, 8'h6a);
		rd(IDX_RES_LOW, 8'h50);
		wr(IDX_CONTROL, 8'h50);
		// Abort in mid-run keeps the old result
		wr(IDX_CONTROL, 8'h54);
		repeat (10) @(posedge clk);
		wr(IDX_CONTROL, 8'h50);
		repeat (70) @(posedge clk);
		rd(IDX_CONTROL, 8'h50);
		rd(IDX_RES_HIGH, 8'h6a);
		// Reset in mid-run
		wr(IDX_CONTROL, 8'h54);
		repeat (10) @(posedge clk);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rd(IDX_CONTROL, 8'h00);
		rd(IDX_RC_OSC, 8'h3f);
		tally_and_finish();
	end
endmodule : adccs_top_test
